/* cms_pkg.sv */
package cms_pkg;
    // ****************************************
    // Register map and reset values
    // ****************************************
    localparam logic [7:0] ADDR_SETUP = 8'h0f;
    localparam logic [7:0] ADDR_TIMER = 8'h10;
    localparam logic [7:0] ADDR_DAC = 8'h11;
    localparam logic [7:0] ADDR_RESTART = 8'h00;
    localparam logic [7:0] RST_SETUP = 8'h19;
    localparam logic [7:0] RST_TIMER = 8'h00;
    localparam logic [7:0] RST_DAC = 8'hc0;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_CONST = 7;
    localparam int BIT_CMP_HI = 6;
    localparam int BIT_CMP_LO = 5;
    localparam int BIT_CONV_EN = 4;
    localparam int BIT_DAC_ON = 7;
    localparam int BIT_DAC_AUTO = 6;

    // ****************************************
    // Operating and comparator modes
    // ****************************************
    localparam logic [2:0] MD_IDLE = 3'h0;
    localparam logic [2:0] MD_CONT = 3'h1;
    localparam logic [2:0] MD_SINGLE = 3'h2;
    localparam logic [2:0] MD_SLEEP = 3'h3;
    localparam logic [1:0] CMP_NEG = 2'h0;
    localparam logic [1:0] CMP_POS = 2'h1;
    localparam logic [1:0] CMP_IN = 2'h2;
    localparam logic [1:0] CMP_OUT = 2'h3;

    // ****************************************
    // Serial slave and offset tracking
    // ****************************************
    localparam logic [7:0] WR_BYTE = 8'h90;
    localparam logic [7:0] RD_BYTE = 8'h91;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] AVG_TOP_QTR = 2'h3;
    localparam logic [1:0] AVG_LOW_QTR = 2'h0;
    localparam logic [5:0] DAC_MAX = 6'h3f;

    // ****************************************
    // Timing
    // ****************************************
    localparam longint STEP_HOURS = 4;
    localparam longint SEC_PER_HOUR = 3600;
    localparam longint CLK_HZ = 125000000;
    localparam logic [47:0] STEP_CYCLES =
        48'(STEP_HOURS * SEC_PER_HOUR * CLK_HZ);

    typedef enum logic [6:0] {
        I_IDLE = 7'h01,
        I_ADDR = 7'h02,
        I_PTR = 7'h04,
        I_WDAT = 7'h08,
        I_TACK = 7'h10,
        I_RDAT = 7'h20,
        I_RACK = 7'h40
    } cms_i2c_t;
endpackage : cms_pkg

/* cms_cmp_if.sv */
`timescale 1ns/1ps
interface cms_cmp_if;
    logic [15:0] data;
    logic [15:0] avg;
    logic [15:0] sens;
    logic [15:0] thr;
    logic fixed;
    logic [1:0] mode;
    logic valid;
    logic detect;
    modport core (output data, avg, sens, thr, fixed, mode, valid,
        input detect);
    modport cmp (input data, avg, sens, thr, fixed, mode, valid,
        output detect);
endinterface : cms_cmp_if

/* cms_compare.sv */
`timescale 1ns/1ps
module cms_compare (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Comparator link
    cms_cmp_if.cmp cif
);
    typedef struct packed {
        logic detect;
    } cms_cmp_st_t;

    cms_cmp_st_t r;
    cms_cmp_st_t n;
    logic signed [17:0] d;
    logic signed [17:0] lo;
    logic signed [17:0] hi;
    logic signed [17:0] t;
    logic below;
    logic above;
    logic hit;

    // ****************************************
    // Detection decision
    // ****************************************
    always_comb begin
        d = $signed({2'b00, cif.data});
        t = $signed({2'b00, cif.thr});
        lo = $signed({2'b00, cif.avg}) - $signed({2'b00, cif.sens});
        hi = $signed({2'b00, cif.avg}) + $signed({2'b00, cif.sens});
        below = d < lo;
        above = d > hi;
        hit = 1'b0;
        if (cif.fixed) begin
            // Window codes have no fixed form
            if (cif.mode == cms_pkg::CMP_NEG) begin
                hit = d < t;
            end else if (cif.mode == cms_pkg::CMP_POS) begin
                hit = d > t;
            end
        end else begin
            case (cif.mode)
                cms_pkg::CMP_NEG: hit = below;
                cms_pkg::CMP_POS: hit = above;
                cms_pkg::CMP_IN: hit = d > lo && d < hi;
                default: hit = below || above;
            endcase
        end
        n = r;
        if (cif.valid) begin
            n.detect = hit;
        end
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign cif.detect = r.detect;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    neg_mode_a: assert property (
        cif.valid && cif.mode == cms_pkg::CMP_NEG
        |=> cif.detect == $past(cif.fixed ? d < t : d < lo))
        else $error("negative mode detect wrong");
    pos_mode_a: assert property (
        cif.valid && cif.mode == cms_pkg::CMP_POS
        |=> cif.detect == $past(cif.fixed ? d > t : d > hi))
        else $error("positive mode detect wrong");
    in_window_a: assert property (cif.valid && !cif.fixed &&
        cif.mode == cms_pkg::CMP_IN
        |=> cif.detect == $past(!below && !above && d != lo && d != hi))
        else $error("in-window detect wrong");
    out_window_a: assert property (cif.valid && !cif.fixed &&
        cif.mode == cms_pkg::CMP_OUT
        |=> cif.detect == $past(d < lo || d > hi))
        else $error("out-window detect wrong");
endmodule : cms_compare

/* cms_control.sv */
// Notes on behaviour
// - Negative code: detect below lower limit
// - Positive code: detect above upper limit
// - In-window: detect strictly between adaptive limits
// - Out-window: detect outside adaptive limits
// - Mode zero: idle, no conversions
// - Mode one: back-to-back conversions while enabled
// - Mode two: one conversion, then idle
// - Mode three: power down, serial alive
// - Sleep timer register, reset zero
// - No detection within timeout: power down
// - Leave auto sleep only by command
// - Timeout is value times four hours
// - Timer value zero disables auto sleep
// - Offset DAC register with enable, auto
// - Setup register, reset 0x19, constant select
// - Auto DAC steps by average quarter
// - Two-wire slave at 0x90/0x91
`timescale 1ns/1ps
module cms_control #(
    parameter logic [47:0] step_cycles_p = cms_pkg::STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Two-wire serial pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // Converter core
    input wire logic [15:0] conv_data_i,
    input wire logic [15:0] avg_data_i,
    input wire logic [15:0] sens_i,
    input wire logic [15:0] thresh_i,
    input wire logic conv_done_i,
    output logic conv_start_o,
    output logic powerdown_o,
    output logic detect_o,
    // Offset capacitance DAC
    output logic offset_dac_on_o,
    output logic [5:0] offset_dac_code_o
);
    typedef struct packed {
        logic scl1;
        logic scl2;
        logic scl3;
        logic sda1;
        logic sda2;
        logic sda3;
        logic scl;
        logic sda;
        cms_pkg::cms_i2c_t st;
        cms_pkg::cms_i2c_t ack_nx;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic nak;
        logic [7:0] ptr;
        logic oe;
        logic [7:0] setup;
        logic [7:0] timer;
        logic [7:0] dac;
        logic busy;
        logic start;
        logic pd;
        logic [47:0] cyc;
        logic [5:0] steps;
    } cms_ctl_st_t;

    cms_ctl_st_t r;
    cms_ctl_st_t n;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic wr_en;
    logic done;
    logic [2:0] mode;
    logic [5:0] tmo;
    logic [7:0] rd_next;
    cms_cmp_if cif();

    // ****************************************
    // Comparator hookup
    // ****************************************
    assign cif.data = conv_data_i;
    assign cif.avg = avg_data_i;
    assign cif.sens = sens_i;
    assign cif.thr = thresh_i;
    assign cif.fixed = r.setup[cms_pkg::BIT_CONST];
    assign cif.mode = {r.setup[cms_pkg::BIT_CMP_HI],
        r.setup[cms_pkg::BIT_CMP_LO]};
    assign cif.valid = done;

    cms_compare u_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cif(cif)
    );

    // Register read decode
    function automatic logic [7:0] rd_reg(input cms_ctl_st_t s,
        input logic [7:0] a);
        if (a == cms_pkg::ADDR_SETUP) begin
            rd_reg = s.setup;
        end else if (a == cms_pkg::ADDR_TIMER) begin
            rd_reg = s.timer;
        end else if (a == cms_pkg::ADDR_DAC) begin
            rd_reg = s.dac;
        end else begin
            rd_reg = cms_pkg::READ_NONE;
        end
    endfunction : rd_reg

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = r;
        n.start = 1'b0;
        wr_en = 1'b0;
        mode = r.setup[2:0];
        tmo = r.timer[5:0];
        done = r.busy && conv_done_i;
        rd_next = rd_reg(r, r.ptr + 8'h01);
        // Pin synchronisers, change taken when stages agree
        n.scl1 = scl_i;
        n.scl2 = r.scl1;
        n.scl3 = r.scl2;
        n.sda1 = sda_i;
        n.sda2 = r.sda1;
        n.sda3 = r.sda2;
        if (r.scl2 == r.scl3) begin
            n.scl = r.scl2;
        end
        if (r.sda2 == r.sda3) begin
            n.sda = r.sda2;
        end
        scl_rise = n.scl && !r.scl;
        scl_fall = !n.scl && r.scl;
        bus_start = r.scl && n.scl && r.sda && !n.sda;
        bus_stop = r.scl && n.scl && !r.sda && n.sda;

        // Serial slave engine
        if (bus_start) begin
            n.st = cms_pkg::I_ADDR;
            n.cnt = 4'h0;
            n.oe = 1'b0;
        end else if (bus_stop) begin
            if (r.rw) begin
                n.ptr = cms_pkg::ADDR_RESTART;
            end
            n.rw = 1'b0;
            n.st = cms_pkg::I_IDLE;
            n.oe = 1'b0;
        end else begin
            case (r.st)
                cms_pkg::I_ADDR, cms_pkg::I_PTR, cms_pkg::I_WDAT: begin
                    if (scl_rise) begin
                        n.sh = {r.sh[6:0], n.sda};
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall && r.cnt == cms_pkg::BITS_PER_BYTE) begin
                        n.cnt = 4'h0;
                        n.oe = 1'b1;
                        n.st = cms_pkg::I_TACK;
                        n.ack_nx = cms_pkg::I_WDAT;
                        if (r.st == cms_pkg::I_ADDR) begin
                            if (r.sh[7:1] != cms_pkg::WR_BYTE[7:1]) begin
                                n.st = cms_pkg::I_IDLE;
                                n.oe = 1'b0;
                            end else begin
                                n.rw = r.sh[0];
                                n.ack_nx = r.sh[0] ? cms_pkg::I_RDAT :
                                    cms_pkg::I_PTR;
                            end
                        end else if (r.st == cms_pkg::I_PTR) begin
                            n.ptr = r.sh;
                        end else begin
                            wr_en = 1'b1;
                            n.ptr = r.ptr + 8'h01;
                        end
                    end
                end
                cms_pkg::I_TACK: begin
                    if (scl_fall) begin
                        n.st = r.ack_nx;
                        n.oe = 1'b0;
                        if (r.ack_nx == cms_pkg::I_RDAT) begin
                            n.sh = rd_reg(r, r.ptr);
                            n.oe = !n.sh[7];
                        end
                    end
                end
                cms_pkg::I_RDAT: begin
                    if (scl_rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end
                    if (scl_fall) begin
                        if (r.cnt == cms_pkg::BITS_PER_BYTE) begin
                            n.oe = 1'b0;
                            n.cnt = 4'h0;
                            n.st = cms_pkg::I_RACK;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe = !r.sh[6];
                        end
                    end
                end
                cms_pkg::I_RACK: begin
                    if (scl_rise) begin
                        n.nak = n.sda;
                    end
                    if (scl_fall) begin
                        if (r.nak) begin
                            n.st = cms_pkg::I_IDLE;
                        end else begin
                            n.ptr = r.ptr + 8'h01;
                            n.sh = rd_next;
                            n.oe = !rd_next[7];
                            n.st = cms_pkg::I_RDAT;
                        end
                    end
                end
                default: begin
                    n.st = cms_pkg::I_IDLE;
                end
            endcase
        end

        // Conversion sequencing
        if (done) begin
            n.busy = 1'b0;
            if (mode == cms_pkg::MD_SINGLE) begin
                n.setup[2:0] = cms_pkg::MD_IDLE;
            end
            // Offset tracking on each finished conversion
            if (r.dac[cms_pkg::BIT_DAC_ON] && r.dac[cms_pkg::BIT_DAC_AUTO]
                && !r.setup[cms_pkg::BIT_CONST]) begin
                if (avg_data_i[15:14] == cms_pkg::AVG_TOP_QTR &&
                    r.dac[5:0] != cms_pkg::DAC_MAX) begin
                    n.dac[5:0] = r.dac[5:0] + 6'h01;
                end else if (avg_data_i[15:14] == cms_pkg::AVG_LOW_QTR &&
                    r.dac[5:0] != 6'h00) begin
                    n.dac[5:0] = r.dac[5:0] - 6'h01;
                end
            end
        end else if (!r.busy && r.setup[cms_pkg::BIT_CONV_EN] &&
            (mode == cms_pkg::MD_CONT || mode == cms_pkg::MD_SINGLE)) begin
            n.start = 1'b1;
            n.busy = 1'b1;
        end

        // Auto sleep timeout, counted in four-hour steps
        if (tmo == 6'h00 || mode == cms_pkg::MD_SLEEP || cif.detect) begin
            n.cyc = 48'h0;
            n.steps = 6'h00;
        end else if (r.cyc == step_cycles_p - 48'h1) begin
            n.cyc = 48'h0;
            n.steps = r.steps + 6'h01;
            if (r.steps + 6'h01 == tmo) begin
                n.steps = 6'h00;
                n.setup[2:0] = cms_pkg::MD_SLEEP;
            end
        end else begin
            n.cyc = r.cyc + 48'h1;
        end

        // Host writes override hardware updates
        if (wr_en) begin
            if (r.ptr == cms_pkg::ADDR_SETUP) begin
                n.setup = r.sh;
            end else if (r.ptr == cms_pkg::ADDR_TIMER) begin
                n.timer = r.sh;
                n.cyc = 48'h0;
                n.steps = 6'h00;
            end else if (r.ptr == cms_pkg::ADDR_DAC) begin
                n.dac = r.sh;
            end
        end
        // Only a register write leaves sleep
        n.pd = n.setup[2:0] == cms_pkg::MD_SLEEP;
    end

    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r <= '0;
            r.scl1 <= 1'b1;
            r.scl2 <= 1'b1;
            r.scl3 <= 1'b1;
            r.sda1 <= 1'b1;
            r.sda2 <= 1'b1;
            r.sda3 <= 1'b1;
            r.scl <= 1'b1;
            r.sda <= 1'b1;
            r.st <= cms_pkg::I_IDLE;
            r.ack_nx <= cms_pkg::I_IDLE;
            r.setup <= cms_pkg::RST_SETUP;
            r.timer <= cms_pkg::RST_TIMER;
            r.dac <= cms_pkg::RST_DAC;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign sda_o = 1'b0;
    assign sda_oe_o = r.oe;
    assign conv_start_o = r.start;
    assign powerdown_o = r.pd;
    assign detect_o = cif.detect;
    assign offset_dac_on_o = r.dac[cms_pkg::BIT_DAC_ON];
    assign offset_dac_code_o = r.dac[5:0];

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_cont_done;
        done && mode == cms_pkg::MD_CONT && r.setup[cms_pkg::BIT_CONV_EN]
        ##1 (mode == cms_pkg::MD_CONT && r.setup[cms_pkg::BIT_CONV_EN]);
    endsequence

    sequence s_single_done;
        done && mode == cms_pkg::MD_SINGLE && !wr_en;
    endsequence

    idle_quiet_a: assert property (mode == cms_pkg::MD_IDLE &&
        $past(mode) == cms_pkg::MD_IDLE |-> !conv_start_o)
        else $error("start issued while idle");
    cont_b2b_a: assert property (s_cont_done |=> conv_start_o)
        else $error("continuous mode did not restart");
    enable_gate_a: assert property
        (!r.setup[cms_pkg::BIT_CONV_EN] |=> !conv_start_o)
        else $error("start without conversion enable");
    single_idle_a: assert property (s_single_done
        |=> mode == cms_pkg::MD_IDLE ##1 !conv_start_o)
        else $error("single mode did not return to idle");
    sleep_hold_a: assert property (r.pd && !wr_en |=> r.pd)
        else $error("left power down without command");
    no_auto_a: assert property (tmo == 6'h00 && !r.pd && !wr_en
        |=> !r.pd)
        else $error("auto sleep with zero timer");
    auto_sleep_a: assert property (
        tmo != 6'h00 && !r.pd && !wr_en &&
        !cif.detect && r.cyc == step_cycles_p - 48'h1 &&
        r.steps + 6'h01 == tmo |=> r.pd)
        else $error("timeout did not power down");
    timer_restart_a: assert property (
        wr_en && r.ptr == cms_pkg::ADDR_TIMER
        |=> r.cyc == 48'h0 && r.steps == 6'h00)
        else $error("timer write did not restart count");
    dac_up_a: assert property (
        done && !wr_en && r.dac[7] && r.dac[6] &&
        !r.setup[cms_pkg::BIT_CONST] && avg_data_i[15:14] == 2'h3 &&
        r.dac[5:0] != 6'h3f
        |=> r.dac[5:0] == $past(r.dac[5:0]) + 6'h01)
        else $error("auto dac did not step up");
    dac_fixed_a: assert property (
        r.setup[cms_pkg::BIT_CONST] && !wr_en |=> $stable(r.dac))
        else $error("dac moved in constant mode");
    ack_drive_a: assert property (
        r.st == cms_pkg::I_TACK |-> sda_oe_o)
        else $error("ack not driven low");
endmodule : cms_control

/* cms_host_model.sv */
`timescale 1ns/1ps
// ****
// Two-wire bus master stand-in
// ****
module cms_host_model (
    // Clock and resolved data wire
    input wire logic clk_i,
    input wire logic sda_i,
    // Bus drive, clock push-pull, data open drain
    output logic scl_o,
    output logic sda_oe_o
);
    // Bus idles released
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Whole clocks, then step off the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : w
    // One bit, 1 releases; data moves only while clock is low
    task automatic bx(input logic b, output logic r);
        w(5);
        sda_oe_o = ~b;
        w(5);
        scl_o = 1'b1;
        w(5);
        r = sda_i;
        w(5);
        scl_o = 1'b0;
    endtask : bx
    // Start: data falls while clock high
    task automatic st();
        sda_oe_o = 1'b1;
        w(10);
        scl_o = 1'b0;
    endtask : st
    // Stop: data rises while clock high
    task automatic sp();
        w(5);
        sda_oe_o = 1'b1;
        w(5);
        scl_o = 1'b1;
        w(10);
        sda_oe_o = 1'b0;
        w(10);
    endtask : sp
    // Byte out MSB first, a is the slave acknowledge
    task automatic bt(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bx(d[i], r);
        end
        bx(1'b1, r);
        a = ~r;
    endtask : bt
    // Byte in, m selects acknowledge
    task automatic rb(input logic m, output logic [7:0] d);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bx(1'b1, r);
            d = {d[6:0], r};
        end
        bx(~m, r);
    endtask : rb
    // Register write, ok when all three bytes acknowledged
    task automatic wr(input logic [7:0] ad, input logic [7:0] d,
        output logic ok);
        logic a0, a1, a2;
        st();
        bt(8'h90, a0);
        bt(ad, a1);
        bt(d, a2);
        sp();
        ok = a0 & a1 & a2;
    endtask : wr
    // Pointer set, then n bytes read, last one refused
    task automatic rd(input logic [7:0] ad, input int n,
        output logic [15:0] d);
        logic a;
        logic [7:0] b;
        st();
        bt(8'h90, a);
        bt(ad, a);
        sp();
        st();
        bt(8'h91, a);
        for (int i = 0; i < n; i++) begin
            rb(i < n - 1, b);
            d = {d[7:0], b};
        end
        sp();
    endtask : rd
    // Address byte alone
    task automatic probe(input logic [7:0] ab, output logic a);
        st();
        bt(ab, a);
        sp();
    endtask : probe
endmodule : cms_host_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
    // ****
    // Signals and instances
    // ****
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic done = 1'b0;
    logic scl, host_oe, sda_oe, conv_start, pd, det, dac_on, ok;
    logic sda_val;
    logic [15:0] data = 16'h0000;
    logic [15:0] avg = 16'h0000;
    logic [15:0] rv;
    logic [5:0] code;
    int error_cnt = 0;
    int num_checks = 0;
    int starts = 0;
    int n;
    wire sda = ~(sda_oe | host_oe);
    always #4 clk_i = ~clk_i;
    // Core stand-in: done one cycle after each start
    always @(posedge clk_i) begin
        done <= conv_start;
        if (conv_start === 1'b1) starts++;
    end
    cms_control #(.step_cycles_p(48'd20)) cms_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_val), .sda_oe_o(sda_oe), .conv_data_i(data),
        .avg_data_i(avg), .sens_i(16'h000a), .thresh_i(16'h03e8),
        .conv_done_i(done), .conv_start_o(conv_start),
        .powerdown_o(pd), .detect_o(det), .offset_dac_on_o(dac_on),
        .offset_dac_code_o(code));
    cms_host_model cms_host_model_inst (.clk_i(clk_i), .sda_i(sda),
        .scl_o(scl), .sda_oe_o(host_oe));
    // ****
    // Helpers
    // ****
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        cms_host_model_inst.wr(ad, d, ok);
        chk(ok, 1'b1);
    endtask : wr
    task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
        cms_host_model_inst.rd(ad, 1, rv);
        chk(rv[7:0], e);
    endtask : rdc
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rdc(8'h0f, 8'h19);
        rdc(8'h10, 8'h00);
        rdc(8'h11, 8'hc0);
        chk(dac_on, 1'b1);
        chk(sda_val, 1'b0);
    endtask : t_reset
    task automatic t_bus();
        cms_host_model_inst.probe(8'h92, ok);
        chk(ok, 1'b0);
        wr(8'h05, 8'h5a);
        rdc(8'h05, 8'h00);
        cms_host_model_inst.rd(8'h0f, 2, rv);
        chk(rv, 16'h1900);
    endtask : t_bus
    task automatic t_cmp();
        logic [3:0] ex [8] = '{4'h1, 4'h8, 4'h4, 4'h9, 4'h3, 4'h8, 4'h0,
            4'h0};
        logic [15:0] dv [4] = '{16'h03d4, 16'h03de, 16'h03e8, 16'h03fc};
        avg = 16'h03e8;
        for (int m = 0; m < 8; m++) begin
            wr(8'h0f, {m > 3, 2'(m > 3 ? m - 4 : m), 5'h11});
            for (int d = 0; d < 4; d++) begin
                data = dv[d];
                cyc(8);
                chk(det, ex[m][d]);
            end
        end
    endtask : t_cmp
    task automatic t_modes();
        wr(8'h0f, 8'h10);
        n = starts;
        cyc(30);
        chk(starts - n, 0);
        n = starts;
        wr(8'h0f, 8'h12);
        cyc(20);
        chk(starts - n, 1);
        rdc(8'h0f, 8'h10);
        wr(8'h0f, 8'h01);
        n = starts;
        cyc(30);
        chk(starts - n, 0);
        wr(8'h0f, 8'h11);
        n = starts;
        cyc(60);
        chk(starts - n >= 19 && starts - n <= 21, 1'b1);
        wr(8'h0f, 8'h13);
        n = starts;
        chk(pd, 1'b1);
        rdc(8'h0f, 8'h13);
        chk(starts - n, 0);
    endtask : t_modes
    task automatic t_timer();
        data = 16'h03e8;
        wr(8'h0f, 8'h11);
        wr(8'h10, 8'h03);
        chk(pd, 1'b0);
        n = 0;
        while (pd !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(n >= 12 && n <= 16, 1'b1);
        cyc(100);
        chk(pd, 1'b1);
        rdc(8'h0f, 8'h13);
        data = 16'h03fc;
        wr(8'h0f, 8'h31);
        chk(pd, 1'b0);
        cyc(200);
        chk(pd, 1'b0);
        chk(det, 1'b1);
        wr(8'h10, 8'h00);
        data = 16'h03e8;
        cyc(200);
        chk(pd, 1'b0);
    endtask : t_timer
    task automatic t_dac();
        wr(8'h11, 8'h25);
        chk(dac_on, 1'b0);
        chk(code, 6'h25);
        rdc(8'h11, 8'h25);
        avg = 16'hf000;
        wr(8'h11, 8'hfb);
        cyc(30);
        chk(code, 6'h3f);
        wr(8'h0f, 8'h91);
        wr(8'h11, 8'hc5);
        cyc(30);
        chk(code, 6'h05);
        avg = 16'h0000;
        wr(8'h0f, 8'h11);
        cyc(30);
        chk(code, 6'h00);
    endtask : t_dac
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        cyc(10);
        t_reset();
        t_bus();
        t_cmp();
        t_modes();
        t_timer();
        t_dac();
        finish_test();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk_i);
        error_cnt++;
        finish_test();
    end
endmodule : tb
